// file: design/ssgi_sideband.v
// Sideband status, interrupt and GPIO logic of a video-link serializer
// Behaviour
// - Power-down low resets every control register to its default.
// - Any interconnect fault clears link-detect bit 0 of 0x0c.
// - Only one fault flag; no indication of which fault.
// - Active-low irq output for enabled sources set in 0xc6/0xc7.
// - Remote irq input falling with enables set and link detected drives irq low.
// - Reading irq status clears pending interrupt and releases irq.
// - New remote interrupt only on next falling edge of remote input.
// - Remote mirror output follows the remote irq input level.
// - Remote mirror is held high while no link exists.
// - GPIO0..3 nibbles: 0x3 forward channel, 0x5 back channel.
// - Register-only pins 5..8 are register driven or sampled.
// - Register-only mode overrides shared audio inputs.
// - Register-only pin states are never sent across the link.
// - Local nibble 0x1 drives low, 0x9 high, 0x3 input.
// - Register-only nibbles at 0x10 and 0x11, pin 5 lowest.
// - Input levels at 0x1c and 0x1d bit 0.
`timescale 1ns/1ps
`include "ssgi_map.vh"

module ssgi_sideband
(
  input  wire        mclk,
  input  wire        rstn,
  input  wire        clk_en,
  input  wire        power_down_n,
  input  wire        link_fault,
  input  wire        link_up,
  input  wire        remote_irq_in_n,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  output wire        irq_out_n,
  output wire        remote_irq_mirror,
  input  wire [3:0]  gpio_in,
  output reg  [3:0]  gpio_out,
  output reg  [3:0]  gpio_oe_n,
  input  wire [3:0]  gpio_bc_in,
  output reg  [3:0]  gpio_fc_out,
  input  wire [3:0]  regio_in,
  output reg  [3:0]  regio_out,
  output reg  [3:0]  regio_oe_n,
  input  wire [3:0]  audio_in,
  output wire [3:0]  audio_to_core
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg  [15:0] s1_r;
  reg  [15:0] s2_r;
  wire [15:0] raw;
  wire        pd_n_s;
  wire        fault_s;
  wire        link_s;
  wire        rem_s;
  wire [3:0]  gpio_s;
  wire [3:0]  regio_s;
  wire [3:0]  audio_s;

  assign raw = {audio_in, regio_in, gpio_in,
                remote_irq_in_n, link_up, link_fault, power_down_n};
  assign pd_n_s  = s2_r[0];
  assign fault_s = s2_r[1];
  assign link_s  = s2_r[2];
  assign rem_s   = s2_r[3];
  assign gpio_s  = s2_r[7:4];
  assign regio_s = s2_r[11:8];
  assign audio_s = s2_r[15:12];

  // Power-down bit resets low so control state stays cleared
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      s1_r <= 16'hfffe;
      s2_r <= 16'hfffe;
    end
    else if (clk_en)
    begin
      s1_r <= raw;
      s2_r <= s1_r;
    end
  end

  // Reset or synced power-down clears all control state
  wire rst_all;
  assign rst_all = !rstn || !pd_n_s;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  reg [7:0] gpio0_cfg_r;
  reg [7:0] gpio12_cfg_r;
  reg [7:0] gpio3_cfg_r;
  reg [7:0] regio56_cfg_r;
  reg [7:0] regio78_cfg_r;
  reg [7:0] ictl_r;

  always @(posedge mclk)
  begin
    if (rst_all)
    begin
      gpio0_cfg_r   <= `SSGI_CFG_RESET;
      gpio12_cfg_r  <= `SSGI_CFG_RESET;
      gpio3_cfg_r   <= `SSGI_CFG_RESET;
      regio56_cfg_r <= `SSGI_CFG_RESET;
      regio78_cfg_r <= `SSGI_CFG_RESET;
      ictl_r        <= `SSGI_ICTL_RESET;
    end
    else if (clk_en && reg_wr)
    begin
      case (reg_addr)
        `SSGI_GPIO0_CONFIG:         gpio0_cfg_r   <= reg_wdata;
        `SSGI_GPIO1_GPIO2_CONFIG:   gpio12_cfg_r  <= reg_wdata;
        `SSGI_GPIO3_CONFIG:         gpio3_cfg_r   <= reg_wdata;
        `SSGI_REGIO5_REGIO6_CONFIG: regio56_cfg_r <= reg_wdata;
        `SSGI_REGIO7_REGIO8_CONFIG: regio78_cfg_r <= reg_wdata;
        `SSGI_INTERRUPT_CONTROL:    ictl_r        <= reg_wdata;
        default:                    ictl_r        <= ictl_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Link detect and interrupts
  // ----------------------------------------------------------------
  reg       link_det_r;
  reg       rem_prev_r;
  reg       link_prev_r;
  reg [7:0] isr_r;
  wire      rem_fall;
  wire      link_drop;
  wire      isr_rd;
  wire      rem_en;

  // Single flag for all fault kinds
  always @(posedge mclk)
  begin
    if (rst_all)
      link_det_r <= 1'b0;
    else if (clk_en)
      link_det_r <= link_s && !fault_s;
  end

  assign rem_en = ictl_r[`SSGI_IRQ_GLOBAL_EN_BIT] &&
                  ictl_r[`SSGI_IRQ_REMOTE_EN_BIT];
  assign rem_fall  = rem_prev_r && !rem_s && link_det_r;
  assign link_drop = link_prev_r && !link_det_r;
  assign isr_rd    = reg_rd && (reg_addr == `SSGI_IRQ_STATUS);

  always @(posedge mclk)
  begin
    if (rst_all)
    begin
      rem_prev_r  <= 1'b1;
      link_prev_r <= 1'b0;
      isr_r       <= 8'h00;
    end
    else if (clk_en)
    begin
      rem_prev_r  <= rem_s;
      link_prev_r <= link_det_r;
      // Set wins over read-clear
      isr_r[`SSGI_IRQ_REMOTE_ST_BIT] <= (rem_en && rem_fall) ||
        (isr_r[`SSGI_IRQ_REMOTE_ST_BIT] && !isr_rd);
      isr_r[`SSGI_IRQ_LINK_ST_BIT] <=
        (ictl_r[`SSGI_IRQ_GLOBAL_EN_BIT] &&
         ictl_r[`SSGI_IRQ_LINK_EN_BIT] && link_drop) ||
        (isr_r[`SSGI_IRQ_LINK_ST_BIT] && !isr_rd);
    end
  end

  assign irq_out_n = !(ictl_r[`SSGI_IRQ_GLOBAL_EN_BIT] &&
                       (|isr_r));
  assign remote_irq_mirror = link_det_r ? rem_s : 1'b1;

  // ----------------------------------------------------------------
  // GPIO pins
  // ----------------------------------------------------------------
  wire [15:0] gcfg;
  wire [15:0] rcfg;
  reg  [3:0]  gpio_lvl_r;
  reg  [3:0]  regio_lvl_r;
  integer     i;

  assign gcfg = {gpio3_cfg_r[3:0], gpio12_cfg_r, gpio0_cfg_r[3:0]};
  assign rcfg = {regio78_cfg_r, regio56_cfg_r};

  // Pin drivers and level sampling
  always @(posedge mclk)
  begin
    if (rst_all)
    begin
      gpio_out    <= 4'h0;
      gpio_oe_n   <= 4'hf;
      gpio_fc_out <= 4'h0;
      regio_out   <= 4'h0;
      regio_oe_n  <= 4'hf;
      gpio_lvl_r  <= 4'h0;
      regio_lvl_r <= 4'h0;
    end
    else if (clk_en)
    begin
      gpio_lvl_r  <= gpio_s;
      regio_lvl_r <= regio_s;
      for (i = 0; i < 4; i = i + 1)
      begin
        // Forward mode sends pin to link; back mode drives link value
        gpio_fc_out[i] <= (gcfg[i*4 +: 4] == `SSGI_CODE_FWD) &&
                          gpio_s[i];
        if (gcfg[i*4 +: 4] == `SSGI_CODE_BACK)
        begin
          gpio_out[i]  <= gpio_bc_in[i];
          gpio_oe_n[i] <= 1'b0;
        end
        else if (gcfg[i*4 +: 4] == `SSGI_CODE_OUT_L ||
                 gcfg[i*4 +: 4] == `SSGI_CODE_OUT_H)
        begin
          gpio_out[i]  <= gcfg[i*4 + 3];
          gpio_oe_n[i] <= 1'b0;
        end
        else
        begin
          gpio_out[i]  <= 1'b0;
          gpio_oe_n[i] <= 1'b1;
        end
        // Register-only pins stay local to this side
        if (rcfg[i*4 +: 4] == `SSGI_CODE_OUT_L ||
            rcfg[i*4 +: 4] == `SSGI_CODE_OUT_H)
        begin
          regio_out[i]  <= rcfg[i*4 + 3];
          regio_oe_n[i] <= 1'b0;
        end
        else
        begin
          regio_out[i]  <= 1'b0;
          regio_oe_n[i] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared audio inputs
  // ----------------------------------------------------------------
  wire [3:0] aud_mask;
  reg  [3:0] aud_r;
  genvar     g;

  // Register mode masks the shared audio input
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_aud
      assign aud_mask[g] = (rcfg[g*4 +: 4] == `SSGI_CODE_OUT_L ||
                            rcfg[g*4 +: 4] == `SSGI_CODE_OUT_H ||
                            rcfg[g*4 +: 4] == `SSGI_CODE_IN);
    end
  endgenerate

  always @(posedge mclk)
  begin
    if (rst_all)
      aud_r <= 4'h0;
    else if (clk_en)
      aud_r <= audio_s & ~aud_mask;
  end

  assign audio_to_core = aud_r;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (rst_all)
      reg_rdata <= 8'h00;
    else if (clk_en && reg_rd)
    begin
      case (reg_addr)
        `SSGI_LINK_DETECT_STATUS:   reg_rdata <= {7'h00, link_det_r};
        `SSGI_GPIO0_CONFIG:         reg_rdata <= gpio0_cfg_r;
        `SSGI_GPIO1_GPIO2_CONFIG:   reg_rdata <= gpio12_cfg_r;
        `SSGI_GPIO3_CONFIG:         reg_rdata <= gpio3_cfg_r;
        `SSGI_REGIO5_REGIO6_CONFIG: reg_rdata <= regio56_cfg_r;
        `SSGI_REGIO7_REGIO8_CONFIG: reg_rdata <= regio78_cfg_r;
        `SSGI_GPIO_INPUT_LEVELS:
          reg_rdata <= {regio_lvl_r[2:0], 1'b0, gpio_lvl_r};
        `SSGI_REGIO8_INPUT_LEVEL:
          reg_rdata <= {7'h00, regio_lvl_r[3]};
        `SSGI_INTERRUPT_CONTROL:    reg_rdata <= ictl_r;
        `SSGI_IRQ_STATUS:           reg_rdata <= isr_r;
        default:                    reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule

// file: design/ssgi_map.vh
// Register offsets, field codes and timing counts of the sideband block
`ifndef SSGI_MAP_VH
`define SSGI_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SSGI_LINK_DETECT_STATUS   8'h0c
`define SSGI_GPIO0_CONFIG         8'h0d
`define SSGI_GPIO1_GPIO2_CONFIG   8'h0e
`define SSGI_GPIO3_CONFIG         8'h0f
`define SSGI_REGIO5_REGIO6_CONFIG 8'h10
`define SSGI_REGIO7_REGIO8_CONFIG 8'h11
`define SSGI_GPIO_INPUT_LEVELS    8'h1c
`define SSGI_REGIO8_INPUT_LEVEL   8'h1d
`define SSGI_INTERRUPT_CONTROL    8'hc6
`define SSGI_IRQ_STATUS           8'hc7

// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define SSGI_IRQ_GLOBAL_EN_BIT    0
`define SSGI_IRQ_REMOTE_EN_BIT    5
`define SSGI_IRQ_REMOTE_ST_BIT    5
`define SSGI_IRQ_LINK_EN_BIT      1
`define SSGI_IRQ_LINK_ST_BIT      1
`define SSGI_CODE_FWD             4'h3
`define SSGI_CODE_BACK            4'h5
`define SSGI_CODE_OUT_L           4'h1
`define SSGI_CODE_OUT_H           4'h9
`define SSGI_CODE_IN              4'h3
`define SSGI_CFG_RESET            8'h00
`define SSGI_ICTL_RESET           8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SSGI_PD_MIN_US            3000
`define SSGI_CLK_MHZ              250

`endif

// file: sim/ssgi_remote_model.sv
// Behavioural model of the far-side deserializer
`timescale 1ns/1ps
module ssgi_remote_model
(
  input  wire logic       mclk,
  input  wire logic       link_req,
  input  wire logic       irq_req,
  input  wire logic [3:0] bc_val,
  output logic            remote_irq_in_n,
  output logic            link_up,
  output logic [3:0]      gpio_bc_in
);
  logic junk_r = 1'b0;
  always @(posedge mclk)
  begin
    junk_r <= ~junk_r;
    link_up <= link_req;
  end
  // Lines carry noise while no link exists
  assign remote_irq_in_n = link_up ? !irq_req : junk_r;
  assign gpio_bc_in = link_up ? bc_val : {4{junk_r}};
endmodule

// file: sim/ssgi_sideband_asserts.sv
// Port checks of the sideband block
`timescale 1ns/1ps
module ssgi_sideband_asserts
(
  input wire       mclk,
  input wire       rstn,
  input wire       power_down_n,
  input wire       link_fault,
  input wire       link_up,
  input wire       remote_irq_in_n,
  input wire       reg_rd,
  input wire       reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_rdata,
  input wire       irq_out_n,
  input wire       remote_irq_mirror,
  input wire [3:0] gpio_oe_n,
  input wire [3:0] regio_oe_n
);
  logic [2:0] cause_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  always @(posedge mclk)
    cause_r <= (!remote_irq_in_n || link_fault || !link_up) ? 3'h5
               : cause_r - {2'h0, cause_r != 3'h0};
  sequence pd_held;
    !power_down_n [*4];
  endsequence
  sequence status_read;
    reg_rd && reg_addr == 8'hc7;
  endsequence
  a_reset_idle: assert property ($rose(rstn) |-> irq_out_n
    && &gpio_oe_n && &regio_oe_n) else $error("active after reset");
  a_pd_clears: assert property (pd_held |=> irq_out_n
    && &gpio_oe_n && &regio_oe_n) else $error("power down kept state");
  a_irq_cause: assert property ($fell(irq_out_n) |->
    cause_r != 3'h0) else $error("irq without cause");
  a_irq_holds: assert property (!irq_out_n && !reg_wr &&
    !(reg_rd && reg_addr == 8'hc7) && power_down_n &&
    $past(power_down_n, 3) |=> !irq_out_n) else $error("irq dropped");
  a_read_release: assert property (status_read ##0
    cause_r == 3'h0 |=> irq_out_n) else $error("irq kept after read");
  a_mirror_follow: assert property ($past(link_up, 3) &&
    !$past(link_fault, 3) && $past(power_down_n, 3) && $past(rstn) &&
    $past(rstn, 2) && $past(rstn, 3)
    |-> remote_irq_mirror == $past(remote_irq_in_n, 2))
    else $error("mirror wrong");
  a_mirror_nolink: assert property (!link_up && !$past(link_up, 3)
    |-> remote_irq_mirror) else $error("mirror low without link");
  a_fault_flag: assert property (reg_rd && reg_addr == 8'h0c &&
    link_fault && $past(link_fault, 3) |=> !reg_rdata[0])
    else $error("link detect set under fault");
endmodule
bind ssgi_sideband ssgi_sideband_asserts i_ssgi_sideband_asserts (
  .mclk(mclk), .rstn(rstn), .power_down_n(power_down_n),
  .link_fault(link_fault), .link_up(link_up), .reg_rd(reg_rd),
  .remote_irq_in_n(remote_irq_in_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .irq_out_n(irq_out_n), .gpio_oe_n(gpio_oe_n),
  .remote_irq_mirror(remote_irq_mirror), .regio_oe_n(regio_oe_n));

// file: sim/tb_top.sv
// Self-checking bench for the sideband block
`timescale 1ns/1ps
module tb_top;
  logic mclk, rstn, pdn, flt, irq, lnk, ws, rs, ln, rem_n, irq_n, mir;
  logic [7:0] ad, wd, rdat, d;
  logic [3:0] gi, go, goe, bv, bi, fc, ri, ro, roe, ai, ac;
  int err_count = 0, n_checks = 0;
  ssgi_remote_model i_ssgi_remote_model (.mclk(mclk), .link_req(lnk),
    .irq_req(irq), .bc_val(bv), .remote_irq_in_n(rem_n), .link_up(ln),
    .gpio_bc_in(bi));
  ssgi_sideband i_ssgi_sideband (.mclk(mclk), .rstn(rstn), .clk_en(1'b1),
    .power_down_n(pdn), .link_fault(flt), .link_up(ln),
    .remote_irq_in_n(rem_n), .reg_wr(ws), .reg_rd(rs), .reg_addr(ad),
    .reg_wdata(wd), .reg_rdata(rdat), .irq_out_n(irq_n),
    .remote_irq_mirror(mir), .gpio_in(gi), .gpio_out(go), .gpio_oe_n(goe),
    .gpio_bc_in(bi), .gpio_fc_out(fc), .regio_in(ri), .regio_out(ro),
    .regio_oe_n(roe), .audio_in(ai), .audio_to_core(ac));
  initial
  begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // One register access; read data lands in d
  task automatic acc(input logic w, input logic [7:0] a, v);
    tick(1);
    ad = a; wd = v; ws = w; rs = !w;
    tick(1);
    ws = 0; rs = 0; d = rdat;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, m, e);
    acc(0, a, 8'h00);
    chk(nm, d & m, e);
  endtask
  function automatic logic [7:0] pv(input logic oe_n, o);
    return {6'h00, oe_n, o & !oe_n};
  endfunction
  task automatic wait_low;
    for (int i = 0; i < 20 && irq_n !== 1'b0; i++)
      tick(1);
    chk("irq low", {7'h00, irq_n}, 8'h00);
    if (irq_n !== 1'b0)
      finish_test();
  endtask
  task automatic t_regs;
    logic [7:0] a [6] = '{8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'hc6};
    foreach (a[i])
      rc("cfg reset", a[i], 8'hff, 8'h00);
    acc(1, 8'h00, 8'h5a);
    rc("unmapped", 8'h00, 8'hff, 8'h00);
    acc(1, 8'h0d, 8'h09);
    rc("cfg write", 8'h0d, 8'hff, 8'h09);
    chk("cfg pin", pv(goe[0], go[0]), 8'h01);
    // Short hold: the 3 ms minimum exceeds the run budget
    pdn = 0; tick(6); pdn = 1;
    tick(2);
    rc("pd clear", 8'h0d, 8'hff, 8'h00);
    chk("pd pin", pv(goe[0], go[0]), 8'h02);
    chk("no link mirror", {7'h00, mir}, 8'h01);
    lnk = 1; tick(6);
    rc("link ok", 8'h0c, 8'h01, 8'h01);
    flt = 1; tick(6);
    rc("link fault", 8'h0c, 8'h01, 8'h00);
    flt = 0; tick(6);
    $display("test regs and link done");
  endtask
  task automatic t_irq;
    acc(1, 8'hc6, 8'h20);
    irq = 1; tick(8);
    chk("masked irq", {7'h00, irq_n}, 8'h01);
    irq = 0; tick(6);
    acc(0, 8'hc7, 8'h00);
    acc(1, 8'hc6, 8'h21);
    irq = 1;
    wait_low();
    chk("mirror low", {7'h00, mir}, 8'h00);
    rc("remote status", 8'hc7, 8'h20, 8'h20);
    chk("irq released", {7'h00, irq_n}, 8'h01);
    tick(8);
    chk("no retrigger", {7'h00, irq_n}, 8'h01);
    irq = 0; tick(6);
    chk("mirror high", {7'h00, mir}, 8'h01);
    irq = 1;
    wait_low();
    irq = 0; tick(6);
    acc(0, 8'hc7, 8'h00);
    chk("irq idle", {7'h00, irq_n}, 8'h01);
    acc(1, 8'hc6, 8'h03);
    flt = 1;
    wait_low();
    chk("mirror no link", {7'h00, mir}, 8'h01);
    rc("link status", 8'hc7, 8'hff, 8'h02);
    chk("link irq off", {7'h00, irq_n}, 8'h01);
    flt = 0; tick(6);
    $display("test irq done");
  endtask
  task automatic t_gpio;
    logic [3:0] c [3] = '{4'h1, 4'h9, 4'h3};
    logic [7:0] e [3] = '{8'h00, 8'h01, 8'h02};
    foreach (c[i])
    begin
      acc(1, 8'h0d, {4'h0, c[i]});
      acc(1, 8'h10, {4'h3, c[i]});
      tick(2);
      chk("gpio0 pin", pv(goe[0], go[0]), e[i]);
      chk("regio5 pin", pv(roe[0], ro[0]), e[i]);
    end
    chk("fwd value", {7'h00, fc[0]}, 8'h01);
    acc(1, 8'h11, 8'h30); tick(4);
    rc("levels", 8'h1c, 8'h61, 8'h21);
    rc("regio8 level", 8'h1d, 8'h01, 8'h01);
    chk("audio", {4'h0, ac}, 8'h04);
    ri = 4'h2; tick(4);
    rc("levels new", 8'h1c, 8'h60, 8'h40);
    acc(1, 8'h0e, 8'h05); tick(2);
    chk("back chan", pv(goe[1], go[1]), 8'h01);
    $display("test gpio done");
  endtask
  initial
  begin
    rstn = 0; pdn = 1; flt = 0; irq = 0; lnk = 0; ws = 0; rs = 0;
    ad = 8'h00; wd = 8'h00; gi = 4'h5; bv = 4'h6; ri = 4'hd; ai = 4'hf;
    tick(6);
    rstn = 1;
    t_regs();
    t_irq();
    t_gpio();
    finish_test();
  end
endmodule
